// File: led_driver_control_regs.sv
// Control register bank of a dual-channel LED driver
//
// Overview of operation
// - Warn when ADC bits 9:2 exceed threshold
// - Threshold powers up at 138
// - Threshold read/write at 0x06, reset 0x8A
// - Sleep register at 0x07, resets 0x00
// - Sleep 01 sleeps, 00 wakes, others ignored
// - Sleep bits 1-0, upper bits read zero
// - Low register holds code bits 1-0
// - High register holds code bits 9-2
// - First channel at 0x08 and 0x09
// - Second channel at 0x0A and 0x0B
// - Divider select at 0x0C, reset 100b
// - Divider codes give 7 to 98
// - Warning in status bit 3, read clears
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module led_driver_control_regs
  import led_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [9:0] adc_temp_i,
  input wire logic adc_valid_i,
  output logic thermal_warning_flag_o,
  output logic sleep_mode_o,
  output logic [9:0] first_channel_current_code_o,
  output logic [9:0] second_channel_current_code_o,
  output logic [2:0] dimming_clock_divider_o,
  output logic dimming_tick_o
);

  reg_byte_t thr_r;
  reg_byte_t thr_nxt;
  logic [1:0] sleep_field_r;
  logic [1:0] sleep_field_nxt;
  power_state_e power_state_r;
  power_state_e power_state_nxt;
  logic [2:0] div_sel_r;
  logic [2:0] div_sel_nxt;
  logic warn_flag_r;
  logic warn_flag_nxt;
  reg_byte_t rdata_r;
  reg_byte_t rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [1:0] code_lo_r [2];
  logic [7:0] code_hi_r [2];
  logic hot;
  logic rd_status3;
  logic wr_thr;
  logic wr_sleep;
  logic wr_div;

  // Address decode of the parallel register port
  assign wr_thr = reg_wr_i && reg_addr_i == `THR_LIMIT_OFS;
  assign wr_sleep = reg_wr_i && reg_addr_i == `SLEEP_OFS;
  assign wr_div = reg_wr_i && reg_addr_i == `DIV_SEL_OFS;
  assign rd_status3 = reg_rd_i && reg_addr_i == `STATUS3_OFS;

  // Only a fresh ADC sample may raise the warning
  assign hot = adc_valid_i && (adc_temp_i[9:2] > thr_r);

  // Control register next values
  always_comb
  begin
    thr_nxt = thr_r;
    sleep_field_nxt = sleep_field_r;
    div_sel_nxt = div_sel_r;
    power_state_nxt = power_state_r;
    if (wr_thr)
    begin
      thr_nxt = reg_wdata_i;
    end
    if (wr_sleep)
    begin
      sleep_field_nxt = reg_wdata_i[1:0];
      unique case (power_state_r)
        PWR_NORMAL:
        begin
          if (reg_wdata_i[1:0] == `SLEEP_CMD_ON)
          begin
            power_state_nxt = PWR_SLEEP;
          end
        end
        PWR_SLEEP:
        begin
          if (reg_wdata_i[1:0] == `SLEEP_CMD_OFF)
          begin
            power_state_nxt = PWR_NORMAL;
          end
        end
      endcase
    end
    if (wr_div)
    begin
      div_sel_nxt = reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      thr_r <= `THR_LIMIT_RST;
      sleep_field_r <= `SLEEP_RST;
      power_state_r <= PWR_NORMAL;
      div_sel_r <= `DIV_SEL_RST;
    end
    else
    begin
      thr_r <= thr_nxt;
      sleep_field_r <= sleep_field_nxt;
      power_state_r <= power_state_nxt;
      div_sel_r <= div_sel_nxt;
    end
  end

  // Per-channel current code halves, each written on its own
  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
      logic [7:0] lo_ofs;
      logic [7:0] hi_ofs;
      logic [1:0] lo_nxt;
      logic [7:0] hi_nxt;
      assign lo_ofs = `CH1_LO_OFS + 8'(2 * ch);
      assign hi_ofs = `CH1_HI_OFS + 8'(2 * ch);
      always_comb
      begin
        lo_nxt = code_lo_r[ch];
        hi_nxt = code_hi_r[ch];
        if (reg_wr_i && reg_addr_i == lo_ofs)
        begin
          lo_nxt = reg_wdata_i[1:0];
        end
        if (reg_wr_i && reg_addr_i == hi_ofs)
        begin
          hi_nxt = reg_wdata_i;
        end
      end
      always_ff @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          code_lo_r[ch] <= `CODE_LO_RST;
          code_hi_r[ch] <= `CODE_HI_RST;
        end
        else
        begin
          code_lo_r[ch] <= lo_nxt;
          code_hi_r[ch] <= hi_nxt;
        end
      end
    end
  endgenerate

  // Sticky warning; a new event wins over the read that clears it
  always_comb
  begin
    warn_flag_nxt = warn_flag_r;
    if (rd_status3)
    begin
      warn_flag_nxt = 1'b0;
    end
    if (hot)
    begin
      warn_flag_nxt = 1'b1;
    end
  end

  // Read mux; reserved and unmapped positions return zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    rvalid_nxt = reg_rd_i;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `STATUS3_OFS: rdata_nxt[`WARN_FLAG_BIT] = warn_flag_r;
        `THR_LIMIT_OFS: rdata_nxt = thr_r;
        `SLEEP_OFS: rdata_nxt = {6'h00, sleep_field_r};
        `CH1_LO_OFS: rdata_nxt = {6'h00, code_lo_r[0]};
        `CH1_HI_OFS: rdata_nxt = code_hi_r[0];
        `CH2_LO_OFS: rdata_nxt = {6'h00, code_lo_r[1]};
        `CH2_HI_OFS: rdata_nxt = code_hi_r[1];
        `DIV_SEL_OFS: rdata_nxt = {5'h00, div_sel_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      warn_flag_r <= 1'b0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      warn_flag_r <= warn_flag_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Dimming clock generator runs from the stored select
  dimming_clock_divider u_dimming_clock_divider (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sel_i(div_sel_r),
    .tick_o(dimming_tick_o)
  );

  // Outputs straight from the stored registers
  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign thermal_warning_flag_o = warn_flag_r;
  assign sleep_mode_o = power_state_r[1];
  assign first_channel_current_code_o = {code_hi_r[0], code_lo_r[0]};
  assign second_channel_current_code_o = {code_hi_r[1], code_lo_r[1]};
  assign dimming_clock_divider_o = div_sel_r;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  warn_set_a: assert property (hot |=> thermal_warning_flag_o)
    else $error("warning not raised on hot sample");
  warn_clear_a: assert property (rd_status3 && !hot |=> !thermal_warning_flag_o)
    else $error("warning not cleared by status read");
  warn_hold_a: assert property (warn_flag_r && !rd_status3 |=> warn_flag_r)
    else $error("warning dropped without a read");
  warn_read_a: assert property (rd_status3 |=>
    reg_rvalid_o && reg_rdata_o == {4'h0, $past(warn_flag_r), 3'h0})
    else $error("status read returned wrong warning bit");
  // A wake command right after the sleep command may drop the state again
  sleep_enter_a: assert property (wr_sleep && reg_wdata_i[1:0] == 2'h1 |=>
    sleep_mode_o ##1 (sleep_mode_o || $past(wr_sleep)))
    else $error("sleep command not taken");
  sleep_ignore_a: assert property (wr_sleep && reg_wdata_i[1] |=>
    $stable(sleep_mode_o))
    else $error("sleep state changed on ignored code");
  sleep_rsv_a: assert property (reg_rd_i && reg_addr_i == `SLEEP_OFS |=>
    reg_rdata_o[7:2] == 6'h00)
    else $error("sleep reserved bits read nonzero");
  code_hi_a: assert property (reg_wr_i && reg_addr_i == `CH1_HI_OFS |=>
    first_channel_current_code_o[9:2] == $past(reg_wdata_i))
    else $error("first channel high code not stored");
  code_lo_a: assert property (reg_wr_i && reg_addr_i == `CH2_LO_OFS |=>
    second_channel_current_code_o[1:0] == $past(reg_wdata_i[1:0])
    && $stable(second_channel_current_code_o[9:2]))
    else $error("second channel low code wrong");
  div_read_a: assert property (reg_rd_i && reg_addr_i == `DIV_SEL_OFS |=>
    reg_rdata_o == {5'h00, $past(div_sel_r)})
    else $error("divider select read wrong");

  sleep_c: cover property (wr_sleep && reg_wdata_i[1:0] == 2'h1 ##1 sleep_mode_o);
  warn_c: cover property (hot ##1 rd_status3 ##1 !warn_flag_r);
  race_c: cover property (hot && rd_status3);
  div_c: cover property (div_sel_r == 3'h7 && dimming_tick_o);

endmodule

// File: led_ctrl_map.svh
// Register offsets, field positions, reset values and divider ratios
`ifndef LED_CTRL_MAP_SVH
`define LED_CTRL_MAP_SVH

`define STATUS3_OFS 8'h05
`define THR_LIMIT_OFS 8'h06
`define SLEEP_OFS 8'h07
`define CH1_LO_OFS 8'h08
`define CH1_HI_OFS 8'h09
`define CH2_LO_OFS 8'h0A
`define CH2_HI_OFS 8'h0B
`define DIV_SEL_OFS 8'h0C

`define THR_LIMIT_RST 8'h8A
`define SLEEP_RST 2'h0
`define CODE_LO_RST 2'h0
`define CODE_HI_RST 8'h00
`define DIV_SEL_RST 3'h4

`define WARN_FLAG_BIT 3
`define SLEEP_CMD_OFF 2'h0
`define SLEEP_CMD_ON 2'h1

`define DIV_RATIO_0 7'h07
`define DIV_RATIO_1 7'h08
`define DIV_RATIO_2 7'h0A
`define DIV_RATIO_3 7'h0C
`define DIV_RATIO_4 7'h10
`define DIV_RATIO_5 7'h18
`define DIV_RATIO_6 7'h31
`define DIV_RATIO_7 7'h62

`endif

// File: led_ctrl_pkg.sv
// Types shared by the LED driver control register bank
package led_ctrl_pkg;
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b01,
    PWR_SLEEP = 2'b10
  } power_state_e;
  typedef logic [7:0] reg_byte_t;
  typedef logic [9:0] dac_code_t;
  typedef logic [6:0] div_count_t;
endpackage

// File: dimming_clock_divider.sv
// Dimming clock divider: one-cycle tick every N oscillator cycles
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module dimming_clock_divider
  import led_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);

  div_count_t count_r;
  div_count_t count_nxt;
  div_count_t ratio;
  logic tick_r;
  logic tick_nxt;

  // Select to ratio lookup
  always_comb
  begin
    unique case (sel_i)
      3'h0: ratio = `DIV_RATIO_0;
      3'h1: ratio = `DIV_RATIO_1;
      3'h2: ratio = `DIV_RATIO_2;
      3'h3: ratio = `DIV_RATIO_3;
      3'h4: ratio = `DIV_RATIO_4;
      3'h5: ratio = `DIV_RATIO_5;
      3'h6: ratio = `DIV_RATIO_6;
      3'h7: ratio = `DIV_RATIO_7;
    endcase
  end

  // Wrap at >= so a shrinking ratio never strands the counter
  always_comb
  begin
    tick_nxt = 1'b0;
    count_nxt = count_r + 7'h01;
    if (count_r >= ratio - 7'h01)
    begin
      count_nxt = 7'h00;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_r <= 7'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

  div_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (count_r == ratio - 7'h01 && $stable(sel_i)) |=> tick_r && count_r == 7'h00)
    else $error("divider did not wrap at selected ratio");

endmodule

// File: led_host_model.sv
// Host model issuing register writes and reads over the strobe port
`timescale 1ns/1ps
module led_host_model
(
  input wire logic sys_clk_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  logic [7:0] rd_data;
  logic rd_seen;
  // Idle bus at time zero
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Released lines show the inverse so stale values cannot pass
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~addr;
    reg_wdata_o <= ~data;
    #1;
  endtask
  // Answer is registered on the taken edge and sampled 1 ns after it
  task automatic read_reg(input logic [7:0] addr);
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= addr;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~addr;
    #1;
    rd_data = reg_rdata_i;
    rd_seen = reg_rvalid_i;
  endtask
endmodule

// File: led_driver_control_regs_tb.sv
// Self-checking bench for the LED driver control register bank
`timescale 1ns/1ps
module led_driver_control_regs_tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, adc_valid, flag, sleep_mode, tick;
  logic [9:0] adc_temp, code1, code2;
  logic [2:0] div_sel;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ratio[8] = '{7, 8, 10, 12, 16, 24, 49, 98};
  always #2.5 sys_clk_i = ~sys_clk_i;
  led_host_model u_led_host_model (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));
  led_driver_control_regs u_led_driver_control_regs (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .adc_temp_i(adc_temp),
    .adc_valid_i(adc_valid), .thermal_warning_flag_o(flag), .sleep_mode_o(sleep_mode),
    .first_channel_current_code_o(code1), .second_channel_current_code_o(code2),
    .dimming_clock_divider_o(div_sel), .dimming_tick_o(tick));
  // Compare and count
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    u_led_host_model.read_reg(addr);
    chk("rvalid", {9'h000, u_led_host_model.rd_seen}, 10'h001);
    chk("rdata", {2'b00, u_led_host_model.rd_data}, {2'b00, exp});
  endtask
  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard well above the expected run length
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic reset_values();
    logic [7:0] rst_tbl[7] = '{8'h8A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
    chk("code1", code1, 10'h000);
    chk("code2", code2, 10'h000);
    chk("div", {7'h00, div_sel}, 10'h004);
    chk("sleep", {9'h000, sleep_mode}, 10'h000);
    for (int i = 0; i < 7; i++)
      rd_chk(8'h06 + i[7:0], rst_tbl[i]);
  endtask
  task automatic reserved_bits();
    logic [7:0] rb_tbl[7] = '{8'hFF, 8'h03, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h07};
    for (int i = 0; i < 7; i++)
      u_led_host_model.write_reg(8'h06 + i[7:0], 8'hFF);
    for (int i = 0; i < 7; i++)
      rd_chk(8'h06 + i[7:0], rb_tbl[i]);
    chk("code1", code1, 10'h3FF);
    chk("code2", code2, 10'h3FF);
    u_led_host_model.write_reg(8'h09, 8'h5A);
    chk("code1", code1, 10'h16B);
    chk("code2", code2, 10'h3FF);
    u_led_host_model.write_reg(8'h20, 8'h55);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h06, 8'hFF);
  endtask
  task automatic sleep_cmds();
    logic [1:0] cmd[4] = '{2'b01, 2'b10, 2'b00, 2'b11};
    logic exp_s[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      u_led_host_model.write_reg(8'h07, {6'h2A, cmd[i]});
      chk("sleep", {9'h000, sleep_mode}, {9'h000, exp_s[i]});
      rd_chk(8'h07, {6'h00, cmd[i]});
    end
  endtask
  // One ADC sample, flag judged one cycle later
  task automatic sample(input logic [9:0] t, input logic exp);
    @(posedge sys_clk_i);
    adc_valid <= 1'b1;
    adc_temp <= t;
    @(posedge sys_clk_i);
    adc_valid <= 1'b0;
    adc_temp <= ~t;
    #1;
    chk("flag", {9'h000, flag}, {9'h000, exp});
  endtask
  task automatic thermal();
    u_led_host_model.write_reg(8'h06, 8'h8A);
    sample(10'h22B, 1'b0);
    sample(10'h22C, 1'b1);
    rd_chk(8'h05, 8'h08);
    chk("flag", {9'h000, flag}, 10'h000);
    u_led_host_model.write_reg(8'h06, 8'h8B);
    sample(10'h22F, 1'b0);
    // Hot sample held through a status read: the set wins
    @(posedge sys_clk_i);
    adc_valid <= 1'b1;
    adc_temp <= 10'h3FC;
    rd_chk(8'h05, 8'h08);
    chk("flag", {9'h000, flag}, 10'h001);
    @(posedge sys_clk_i);
    adc_valid <= 1'b0;
    rd_chk(8'h05, 8'h08);
    chk("flag", {9'h000, flag}, 10'h000);
  endtask
  // Tick spacing for every divider code
  task automatic divider();
    int n;
    for (int c = 0; c < 8; c++)
    begin
      u_led_host_model.write_reg(8'h0C, {5'h1F, c[2:0]});
      chk("div", {7'h00, div_sel}, {7'h00, c[2:0]});
      for (int k = 0; k < 2; k++)
      begin
        n = 0;
        do
        begin
          @(posedge sys_clk_i);
          #1;
          n++;
        end
        while (tick !== 1'b1 && n < 200);
      end
      chk("period", n[9:0], ratio[c][9:0]);
    end
  endtask
  initial
  begin
    adc_temp = 10'h000;
    adc_valid = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    reset_values();
    reserved_bits();
    sleep_cmds();
    thermal();
    divider();
    final_report();
  end
endmodule
